// ===== hdl/free_running_compare_timer.v
/*
  16-bit free-running timer with two compare registers, automatic
  addition to compare A, clear on match A and three interrupt lines.
  Assumes a single-cycle register master on mclk that reads and
  writes the 16-bit registers as whole words.
*/
`timescale 1ns/1ps
`include "frt_regs.vh"

// Overview of operation
// [R1] 16-bit up-counter, clock select 00 is div-2, 10 is div-32, 11 stops
// [R2] Clock select 01 gives the div-8 prescaled clock
// [R3] Wrap from all ones to zero sets the wrap flag
// [R4] Counter resets to zero
// [R5] Master accesses all 16-bit registers as whole words only
// [R6] Counter compared with A and B; equality sets matching flag
// [R7] Compare registers A and B reset to all ones
// [R8] A and B share one address; select bit picks target
// [R9] Select bit at control bit 4, 0 is A, 1 is B
// [R10] Increment registers reachable only while access bit is set
// [R11] Auto-add mode adds alternating increment to A on each match A
// [R12] First match after enabling auto-add uses the fall increment
// [R13] Software avoids div-2 with increment of one or less
// [R14] Both increment registers reset to all ones
// [R15] Three interrupt lines, each flag AND its enable
// [R16] Enables at bits 3, 2, 1; all reset to zero
// [R17] Flags at bits 3, 2, 1; clear by write 0 after read 1
// [R18] Flag register bit 0 enables counter clear on match A
// [R19] Control bit 6 selects auto-add mode, resets to zero
// [R20] Reserved bits read zero and ignore writes
// [R21] Match fires in last equal state before counter update
// [R22] Clear beats counter write; write beats following increment
// [R23] Write to compare or increment suppresses next-state match
module free_running_compare_timer (
  // Clock and reset
  input  wire        mclk,
  input  wire        nrst,
  // Register port
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output wire [15:0] rdata,
  // Interrupt requests
  output wire        match_a_irq,
  output wire        match_b_irq,
  output wire        wrap_irq
);

  // ************************************************
  // State
  // ************************************************
  reg [15:0] free_running_count_ff;
  reg [15:0] compare_value_a_ff;
  reg [15:0] compare_value_b_ff;
  reg [15:0] compare_increment_rise_ff;
  reg [15:0] compare_increment_fall_ff;
  reg [3:1]  irq_en_ff;
  reg [3:1]  flag_ff;
  reg [3:1]  armed_ff;
  reg        clear_on_match_a_ff;
  reg [1:0]  clock_sel_ff;
  reg        auto_add_mode_ff;
  reg        compare_reg_select_ff;
  reg        increment_reg_access_ff;
  reg        use_fall_ff;
  reg [`PRESCALE_W-1:0] prescale_ff;
  reg        src_ff;
  reg        cnt_wr_ff;
  reg        ocr_a_wr_ff;
  reg        ocr_b_wr_ff;
  reg [15:0] rdata_ff;
  reg        match_a_irq_ff;
  reg        match_b_irq_ff;
  reg        wrap_irq_ff;

  // ************************************************
  // Helpers
  // ************************************************
  function sel_src;
    input [1:0]            cks;
    input [`PRESCALE_W-1:0] pre;
    begin
      case (cks)
        `CKS_DIV2:  sel_src = pre[`PRE_TAP_DIV2];  // [R1]
        `CKS_DIV8:  sel_src = pre[`PRE_TAP_DIV8];  // [R2]
        `CKS_DIV32: sel_src = pre[`PRE_TAP_DIV32]; // [R1]
        default:    sel_src = 1'b0;   // [R1]
      endcase
    end
  endfunction

  function hit;
    input [3:0] a;
    input [3:0] ofs;
    input       strobe;
    begin
      hit = strobe & (a == ofs);
    end
  endfunction

  // ************************************************
  // Decode
  // ************************************************
  wire w_count  = hit(addr, `OFS_COUNT, wr);
  wire w_cmp    = hit(addr, `OFS_COMPARE, wr);
  wire w_cmp_a  = w_cmp & ~compare_reg_select_ff; // [R8] [R9]
  wire w_cmp_b  = w_cmp & compare_reg_select_ff;  // [R8] [R9]
  wire w_rise   = hit(addr, `OFS_INC_RISE, wr)
                  & increment_reg_access_ff;      // [R10]
  wire w_fall   = hit(addr, `OFS_INC_FALL, wr)
                  & increment_reg_access_ff;      // [R10]
  wire w_en     = hit(addr, `OFS_IRQ_EN, wr);
  wire w_flags  = hit(addr, `OFS_FLAGS, wr);
  wire w_cks    = hit(addr, `OFS_CLK_SEL, wr);
  wire w_ctrl   = hit(addr, `OFS_OUT_CTRL, wr);
  wire w_access = hit(addr, `OFS_INC_ACCESS, wr);
  wire r_flags  = hit(addr, `OFS_FLAGS, rd);

  // ************************************************
  // Count tick and compare
  // ************************************************
  // Falling edge of the chosen source; a source switch from high
  // to low counts as an edge, as the real prescaler would see it.
  wire src_now = sel_src(clock_sel_ff, prescale_ff);
  wire tick    = src_ff & ~src_now;

  // Match is taken only on the tick, i.e. in the last equal state
  wire eq_a    = free_running_count_ff == compare_value_a_ff;
  wire eq_b    = free_running_count_ff == compare_value_b_ff;
  wire match_a = tick & eq_a & ~ocr_a_wr_ff; // [R21] [R23]
  wire match_b = tick & eq_b & ~ocr_b_wr_ff; // [R21] [R23]
  wire do_clr  = match_a & clear_on_match_a_ff; // [R18]
  wire wrap    = tick & ~cnt_wr_ff & ~do_clr
                 & (free_running_count_ff == 16'hFFFF); // [R3]

  // ************************************************
  // Counter
  // ************************************************
  reg [15:0] nxt_count;
  always @* begin
    nxt_count = free_running_count_ff;
    if (do_clr) begin
      nxt_count = 16'h0000; // [R22]
    end else if (w_count) begin
      nxt_count = wdata; // [R5]
    end else if (tick & ~cnt_wr_ff) begin
      nxt_count = free_running_count_ff + 16'h0001; // [R1] [R22]
    end
  end

  // ************************************************
  // Compare A with automatic addition
  // ************************************************
  wire [15:0] inc_val = use_fall_ff ? compare_increment_fall_ff
                                    : compare_increment_rise_ff;
  wire        add_now = match_a & auto_add_mode_ff; // [R11]

  reg [15:0] nxt_cmp_a;
  always @* begin
    nxt_cmp_a = compare_value_a_ff;
    if (w_cmp_a) begin
      nxt_cmp_a = wdata;
    end else if (add_now) begin
      nxt_cmp_a = compare_value_a_ff + inc_val; // [R11]
    end
  end

  // ************************************************
  // Flags
  // ************************************************
  // Set beats clear in the same cycle, so no event is lost.
  wire [3:1] set_v = {match_a, match_b, wrap}; // [R6] [R3]
  wire [3:1] clr_v = w_flags ? (armed_ff & ~wdata[3:1])
                             : 3'b000; // [R17]
  wire [3:1] nxt_flag = set_v | (flag_ff & ~clr_v);

  // ************************************************
  // Read mux
  // ************************************************
  reg [15:0] nxt_rdata;
  always @* begin
    nxt_rdata = 16'h0000; // [R20]
    case (addr)
      `OFS_COUNT:
        nxt_rdata = free_running_count_ff;
      `OFS_COMPARE:
        nxt_rdata = compare_reg_select_ff ? compare_value_b_ff
                                          : compare_value_a_ff; // [R8]
      `OFS_INC_RISE:
        if (increment_reg_access_ff) begin
          nxt_rdata = compare_increment_rise_ff; // [R10]
        end
      `OFS_INC_FALL:
        if (increment_reg_access_ff) begin
          nxt_rdata = compare_increment_fall_ff; // [R10]
        end
      `OFS_IRQ_EN:
        nxt_rdata = {12'h000, irq_en_ff, 1'b0}; // [R16] [R20]
      `OFS_FLAGS:
        nxt_rdata = {12'h000, flag_ff, clear_on_match_a_ff}; // [R17]
      `OFS_CLK_SEL:
        nxt_rdata = {14'h0000, clock_sel_ff}; // [R20]
      `OFS_OUT_CTRL:
        nxt_rdata = {9'h000, auto_add_mode_ff, 1'b0,
                     compare_reg_select_ff, 4'h0}; // [R19] [R20]
      `OFS_INC_ACCESS:
        nxt_rdata = {15'h0000, increment_reg_access_ff};
      default:
        nxt_rdata = 16'h0000;
    endcase
    if (!rd) begin
      nxt_rdata = 16'h0000;
    end
  end

  // ************************************************
  // Enable next value
  // ************************************************
  // Requests follow an enable written in this cycle, so a request
  // never outlives its enable by one clock.
  reg [3:1] nxt_irq_en;
  always @* begin
    nxt_irq_en = irq_en_ff;
    if (w_en) begin
      nxt_irq_en = wdata[3:1]; // [R16]
    end
  end

  // ************************************************
  // Prescaler
  // ************************************************
  // Free-running from reset, so the tick phase after reset is fixed
  always @(posedge mclk) begin
    if (!nrst) begin
      prescale_ff <= {`PRESCALE_W{1'b0}};
      src_ff      <= 1'b0;
    end else begin
      prescale_ff <= prescale_ff + {{(`PRESCALE_W-1){1'b0}}, 1'b1};
      src_ff      <= src_now;
    end
  end

  // ************************************************
  // Counter, compare and increment registers
  // ************************************************
  always @(posedge mclk) begin
    if (!nrst) begin
      free_running_count_ff     <= `RST_COUNT;     // [R4]
      compare_value_a_ff        <= `RST_COMPARE;   // [R7]
      compare_value_b_ff        <= `RST_COMPARE;   // [R7]
      compare_increment_rise_ff <= `RST_INCREMENT; // [R14]
      compare_increment_fall_ff <= `RST_INCREMENT; // [R14]
    end else begin
      free_running_count_ff <= nxt_count;
      compare_value_a_ff    <= nxt_cmp_a;
      if (w_cmp_b) begin
        compare_value_b_ff <= wdata;
      end
      if (w_rise) begin
        compare_increment_rise_ff <= wdata;
      end
      if (w_fall) begin
        compare_increment_fall_ff <= wdata;
      end
    end
  end

  // ************************************************
  // Write memory for the conflict rules
  // ************************************************
  // Remember a write for one state so a match, or after a counter write the count step, is dropped;
  // increment writes count too, as they change the sum.
  always @(posedge mclk) begin
    if (!nrst) begin
      cnt_wr_ff   <= 1'b0;
      ocr_a_wr_ff <= 1'b0;
      ocr_b_wr_ff <= 1'b0;
    end else begin
      cnt_wr_ff   <= w_count;                   // [R22]
      ocr_a_wr_ff <= w_cmp_a | w_rise | w_fall; // [R23]
      ocr_b_wr_ff <= w_cmp_b;                   // [R23]
    end
  end

  // ************************************************
  // Increment alternation
  // ************************************************
  // Fall first after enable, then alternate
  always @(posedge mclk) begin
    if (!nrst) begin
      use_fall_ff <= 1'b1;
    end else if (!auto_add_mode_ff) begin
      use_fall_ff <= 1'b1;         // [R12]
    end else if (add_now) begin
      use_fall_ff <= ~use_fall_ff; // [R11] [R12]
    end
  end

  // ************************************************
  // Flags and clear arming
  // ************************************************
  // Only flags seen as 1 by the latest read may be cleared; any
  // write to the flag register disarms, so a stale read cannot clear.
  always @(posedge mclk) begin
    if (!nrst) begin
      flag_ff             <= 3'b000;
      armed_ff            <= 3'b000;
      clear_on_match_a_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag; // [R17]
      if (w_flags) begin
        clear_on_match_a_ff <= wdata[`BIT_CLR_ON_A]; // [R18]
        armed_ff            <= 3'b000;
      end else if (r_flags) begin
        armed_ff <= flag_ff; // [R17]
      end
    end
  end

  // ************************************************
  // Control registers
  // ************************************************
  // Code 11 holds the counter; no reserved source is emulated.
  always @(posedge mclk) begin
    if (!nrst) begin
      irq_en_ff               <= 3'b000;    // [R16]
      clock_sel_ff            <= `CKS_DIV2;
      auto_add_mode_ff        <= 1'b0;      // [R19]
      compare_reg_select_ff   <= 1'b0;
      increment_reg_access_ff <= 1'b0;
    end else begin
      irq_en_ff <= nxt_irq_en; // [R16]
      if (w_cks) begin
        clock_sel_ff <= wdata[1:0]; // [R1]
      end
      if (w_ctrl) begin
        auto_add_mode_ff      <= wdata[`BIT_AUTO_ADD]; // [R19]
        compare_reg_select_ff <= wdata[`BIT_REG_SEL];  // [R9]
      end
      if (w_access) begin
        increment_reg_access_ff <= wdata[`BIT_INC_ACCESS]; // [R10]
      end
    end
  end

  // ************************************************
  // Output registers
  // ************************************************
  // Requests come from next flag and next enable, so they track
  // both without a cycle of lag.
  always @(posedge mclk) begin
    if (!nrst) begin
      rdata_ff       <= 16'h0000;
      match_a_irq_ff <= 1'b0;
      match_b_irq_ff <= 1'b0;
      wrap_irq_ff    <= 1'b0;
    end else begin
      rdata_ff       <= nxt_rdata;
      match_a_irq_ff <= nxt_flag[`BIT_MATCH_A] & nxt_irq_en[`BIT_MATCH_A]; // [R15]
      match_b_irq_ff <= nxt_flag[`BIT_MATCH_B] & nxt_irq_en[`BIT_MATCH_B]; // [R15]
      wrap_irq_ff    <= nxt_flag[`BIT_WRAP] & nxt_irq_en[`BIT_WRAP];       // [R15]
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign rdata       = rdata_ff;
  assign match_a_irq = match_a_irq_ff;
  assign match_b_irq = match_b_irq_ff;
  assign wrap_irq    = wrap_irq_ff;

endmodule // free_running_compare_timer

// ===== hdl/frt_regs.vh
/*
  Register map, field positions and reset values of the 16-bit
  free-running compare timer.
  Assumes a 4-bit word address on the plain register port.
*/
`ifndef FRT_REGS_VH
`define FRT_REGS_VH

// ************************************************
// Register offsets
// ************************************************
`define OFS_COUNT      4'h0
`define OFS_COMPARE    4'h1
`define OFS_INC_RISE   4'h2
`define OFS_INC_FALL   4'h3
`define OFS_IRQ_EN     4'h4
`define OFS_FLAGS      4'h5
`define OFS_CLK_SEL    4'h6
`define OFS_OUT_CTRL   4'h7
`define OFS_INC_ACCESS 4'h8

// ************************************************
// Field positions
// ************************************************
`define BIT_MATCH_A    3
`define BIT_MATCH_B    2
`define BIT_WRAP       1
`define BIT_CLR_ON_A   0
`define BIT_AUTO_ADD   6
`define BIT_REG_SEL    4
`define BIT_INC_ACCESS 0

// ************************************************
// Reset values and codes
// ************************************************
`define RST_COUNT      16'h0000
`define RST_COMPARE    16'hFFFF
`define RST_INCREMENT  16'hFFFF
`define CKS_DIV2       2'h0
`define CKS_DIV8       2'h1
`define CKS_DIV32      2'h2
`define PRESCALE_W     5
`define PRE_TAP_DIV2   0
`define PRE_TAP_DIV8   2
`define PRE_TAP_DIV32  4

`endif

// ===== bench/frt_properties.sv
/* Port checker for the compare timer.
   Sees only the top ports; one mclk domain, nrst low-active. */
`timescale 1ns/1ps
`include "frt_regs.vh"
module frt_properties (
  // Clock and reset
  input wire        mclk,
  input wire        nrst,
  // Register port
  input wire [3:0]  addr,
  input wire [15:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [15:0] rdata,
  // Requests
  input wire        match_a_irq,
  input wire        match_b_irq,
  input wire        wrap_irq
);
  reg  [2:0] en_ff;
  wire [2:0] irq_vec = {match_a_irq, match_b_irq, wrap_irq};
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ***************************
  // Enable shadow and properties
  // ***************************
  always @(posedge mclk) begin
    if (!nrst)
      en_ff <= 3'h0;
    else if (wr && addr == `OFS_IRQ_EN)
      en_ff <= wdata[3:1];
  end
  AST_RST_QUIET: assert property ($rose(nrst) |-> irq_vec == 3'h0)
    else $error("request active after reset");
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside read cycle");
  AST_UNMAPPED: assert property (rd && addr > `OFS_INC_ACCESS |=> rdata == 16'h0000)
    else $error("unmapped address reads nonzero");
  AST_EN_RSVD: assert property (rd && addr == `OFS_IRQ_EN
    |=> (rdata & 16'hFFF1) == 16'h0000)
    else $error("enable reserved bits nonzero");
  AST_FLAG_RSVD: assert property (rd && addr == `OFS_FLAGS
    |=> (rdata & 16'hFFF0) == 16'h0000)
    else $error("flag reserved bits nonzero");
  AST_CKS_RSVD: assert property (rd && addr == `OFS_CLK_SEL
    |=> (rdata & 16'hFFFC) == 16'h0000)
    else $error("clock select reserved bits nonzero");
  AST_OCTL_RSVD: assert property (rd && addr == `OFS_OUT_CTRL
    |=> (rdata & 16'hFFAF) == 16'h0000)
    else $error("control reserved bits nonzero");
  AST_EN_READBACK: assert property (rd && addr == `OFS_IRQ_EN
    |=> rdata[3:1] == $past(en_ff))
    else $error("enable readback wrong");
  AST_IRQ_GATED: assert property ((irq_vec & ~en_ff) == 3'h0)
    else $error("request without its enable");
  AST_IRQ_FLAG: assert property (rd && addr == `OFS_FLAGS
    |=> (rdata[3:1] & $past(irq_vec)) == $past(irq_vec))
    else $error("request without its flag");
  cover property (match_a_irq && match_b_irq);
  cover property (wrap_irq);
  cover property (rd && addr == `OFS_FLAGS && irq_vec != 3'h0);
endmodule // frt_properties

bind free_running_compare_timer frt_properties u_props (
  .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .match_a_irq(match_a_irq), .match_b_irq(match_b_irq), .wrap_irq(wrap_irq)
);

// ===== bench/irq_sink.sv
/* Interrupt controller stand-in: counts rising requests.
   Assumes the three level requests change only on mclk. */
`timescale 1ns/1ps
module irq_sink (
  // Clock and reset
  input  wire       mclk,
  input  wire       nrst,
  // Requests, one line per source
  input  wire       match_a_irq,
  input  wire       match_b_irq,
  input  wire       wrap_irq,
  // Number of request assertions seen
  output reg  [7:0] rises_ff
);
  reg [2:0] last_ff;
  // Each source is a line of its own, so edges are counted per line
  always @(posedge mclk) begin
    last_ff  <= nrst ? {match_a_irq, match_b_irq, wrap_irq} : 3'h0;
    rises_ff <= !nrst ? 8'h00 : rises_ff + {7'h0, match_a_irq & ~last_ff[2]}
      + {7'h0, match_b_irq & ~last_ff[1]} + {7'h0, wrap_irq & ~last_ff[0]};
  end
endmodule // irq_sink

// ===== bench/tb.sv
/* Self-checking bench for the compare timer.
   Assumes the offsets of frt_regs.vh and a 40 MHz mclk. */
`timescale 1ns/1ps
`include "frt_regs.vh"
module tb;
  reg         mclk, nrst, wr, rd;
  reg  [3:0]  addr;
  reg  [15:0] wdata, v;
  wire [15:0] rdata;
  wire        irq_a, irq_b, irq_w;
  wire [7:0]  rises;
  integer     n_fail, comparisons, i;
  integer     cyc = 0;
  free_running_compare_timer uut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .match_a_irq(irq_a), .match_b_irq(irq_b),
    .wrap_irq(irq_w));
  irq_sink ic (.mclk(mclk), .nrst(nrst), .match_a_irq(irq_a), .match_b_irq(irq_b),
    .wrap_irq(irq_w), .rises_ff(rises));
  // ***************************
  // Clock, timeout and tasks
  // ***************************
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      n_fail = n_fail + 1;
      summarize;
    end
  end
  // Whole words only; no byte access exists on this port
  task wr_reg(input [3:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
    end
  endtask
  task chk(input [15:0] e, input [15:0] t);
    begin
      comparisons = comparisons + 1;
      if (^v === 1'bx || v + t < e || v > e + t) begin
        n_fail = n_fail + 1;
        $display("ERROR %0t: got %h want %h", $time, v, e);
      end
    end
  endtask
  task rd_chk(input [3:0] a, input [15:0] e, input [15:0] t);
    begin
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 v = rdata;
      chk(e, t);
    end
  endtask
  task chk_irq(input [2:0] e);
    begin
      #1 v = {13'h0, irq_a, irq_b, irq_w};
      chk({13'h0, e}, 16'h0000);
    end
  endtask
  task summarize;
    begin
      $display("Counts: %0d compared, %0d failed", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    n_fail = 0;
    comparisons = 0;
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    rd_chk(`OFS_COUNT, 16'h0001, 16'h0001);
    wr_reg(`OFS_CLK_SEL, 16'hFFFF);
    rd_chk(`OFS_CLK_SEL, 16'h0003, 16'h0000);
    rd_chk(`OFS_COMPARE, 16'hFFFF, 16'h0000);
    wr_reg(`OFS_OUT_CTRL, 16'hFFFF);
    rd_chk(`OFS_OUT_CTRL, 16'h0050, 16'h0000);
    rd_chk(`OFS_COMPARE, 16'hFFFF, 16'h0000);
    rd_chk(`OFS_INC_RISE, 16'h0000, 16'h0000);
    wr_reg(`OFS_INC_ACCESS, 16'h0001);
    rd_chk(`OFS_INC_RISE, 16'hFFFF, 16'h0000);
    rd_chk(`OFS_INC_FALL, 16'hFFFF, 16'h0000);
    rd_chk(`OFS_IRQ_EN, 16'h0000, 16'h0000);
    rd_chk(`OFS_FLAGS, 16'h0000, 16'h0000);
    rd_chk(4'h9, 16'h0000, 16'h0000);
    $display("Test reset values done");
    wr_reg(`OFS_COUNT, 16'h0010);
    wr_reg(`OFS_COMPARE, 16'h0018);
    wr_reg(`OFS_OUT_CTRL, 16'h0000);
    wr_reg(`OFS_COMPARE, 16'h0014);
    wr_reg(`OFS_IRQ_EN, 16'hFFFF);
    rd_chk(`OFS_IRQ_EN, 16'h000E, 16'h0000);
    wr_reg(`OFS_CLK_SEL, 16'h0000);
    repeat (48) @(posedge mclk);
    chk_irq(3'h6);
    rd_chk(`OFS_FLAGS, 16'h000C, 16'h0000);
    wr_reg(`OFS_FLAGS, 16'h000C);
    rd_chk(`OFS_FLAGS, 16'h000C, 16'h0000);
    wr_reg(`OFS_FLAGS, 16'h0000);
    rd_chk(`OFS_FLAGS, 16'h0000, 16'h0000);
    chk_irq(3'h0);
    $display("Test compare match done");
    wr_reg(`OFS_CLK_SEL, 16'h0003);
    wr_reg(`OFS_COUNT, 16'hFFF0);
    wr_reg(`OFS_CLK_SEL, 16'h0000);
    repeat (40) @(posedge mclk);
    chk_irq(3'h1);
    wr_reg(`OFS_IRQ_EN, 16'h0000);
    chk_irq(3'h0);
    wr_reg(`OFS_FLAGS, 16'h0000);
    rd_chk(`OFS_FLAGS, 16'h0002, 16'h0000);
    wr_reg(`OFS_FLAGS, 16'h0000);
    rd_chk(`OFS_FLAGS, 16'h0000, 16'h0000);
    $display("Test wrap done");
    for (i = 0; i < 3; i = i + 1) begin
      wr_reg(`OFS_CLK_SEL, 16'h0003);
      wr_reg(`OFS_COUNT, 16'h0000);
      wr_reg(`OFS_CLK_SEL, i[15:0]);
      repeat (254) @(posedge mclk);
      wr_reg(`OFS_CLK_SEL, 16'h0003);
      rd_chk(`OFS_COUNT, 16'h0080 >> (2 * i), 16'h0002);
    end
    $display("Test clock rates done");
    wr_reg(`OFS_COUNT, 16'h0000);
    wr_reg(`OFS_COMPARE, 16'h0005);
    rd_chk(`OFS_FLAGS, 16'h000C, 16'h0000);
    wr_reg(`OFS_FLAGS, 16'h0001);
    wr_reg(`OFS_CLK_SEL, 16'h0001);
    repeat (200) @(posedge mclk);
    wr_reg(`OFS_CLK_SEL, 16'h0003);
    rd_chk(`OFS_FLAGS, 16'h0009, 16'h0000);
    rd_chk(`OFS_COUNT, 16'h0003, 16'h0003);
    $display("Test clear on match done");
    wr_reg(`OFS_FLAGS, 16'h0000);
    wr_reg(`OFS_COUNT, 16'h0000);
    wr_reg(`OFS_COMPARE, 16'h0010);
    wr_reg(`OFS_INC_RISE, 16'h0020);
    wr_reg(`OFS_INC_FALL, 16'h0040);
    wr_reg(`OFS_OUT_CTRL, 16'h0040);
    wr_reg(`OFS_CLK_SEL, 16'h0000);
    repeat (100) @(posedge mclk);
    rd_chk(`OFS_COMPARE, 16'h0050, 16'h0000);
    repeat (80) @(posedge mclk);
    rd_chk(`OFS_COMPARE, 16'h0070, 16'h0000);
    wr_reg(`OFS_OUT_CTRL, 16'h0050);
    rd_chk(`OFS_COMPARE, 16'h0018, 16'h0000);
    v = {8'h00, rises};
    chk(16'h0003, 16'h0000);
    $display("Test automatic addition done");
    summarize;
  end
endmodule // tb
